//--- include/fcrs_pkg.sv
// Constants and types shared by the flash rewrite sequencer files
package fcrs_pkg;
    localparam int REG_AW = 4;
    localparam int REG_DW = 32;
    localparam int CMD_AW = 20;
    localparam int CMD_DW = 16;
    localparam int ID_NUM = 7;
    localparam int GRD_NUM = 3;

    // Register byte addresses
    localparam logic [REG_AW-1:0] OFS_CTRL_A = 4'h0;
    localparam logic [REG_AW-1:0] OFS_CTRL_B = 4'h4;
    localparam logic [REG_AW-1:0] OFS_STAT = 4'h8;
    localparam logic [REG_AW-1:0] OFS_MASK = 4'hC;

    // flash_ctrl_reg_a fields
    localparam int BIT_RBF = 0;
    localparam int BIT_CRE = 1;
    localparam int BIT_RC2 = 2;
    localparam int BIT_FPS = 3;
    localparam int BIT_SER_OK = 4;
    localparam int BIT_PAR_OK = 5;
    // flash_ctrl_reg_b field
    localparam int BIT_FRM = 1;

    // Guarded bits: register and position of each
    localparam logic [REG_AW-1:0] GRD_OFS [GRD_NUM] =
        '{OFS_CTRL_A, OFS_CTRL_A, OFS_CTRL_B};
    localparam int GRD_BIT [GRD_NUM] = '{BIT_CRE, BIT_RC2, BIT_FRM};

    // Interrupt status and mask layout
    localparam int EV_DONE = 0;
    localparam int EV_ABORT = 1;
    localparam int EV_ERR = 2;
    localparam int EV_NUM = 3;
    localparam logic [EV_NUM-1:0] EV_RST = 3'h0;

    // Command codes, low byte of the data word
    localparam logic [7:0] CMD_PROG = 8'h40;
    localparam logic [7:0] CMD_LOCK = 8'h77;
    localparam logic [7:0] CMD_LOCK_CONF = 8'hD0;

    // Protection addresses and values
    localparam logic [CMD_AW-1:0] ID_ADDR [ID_NUM] = '{20'hFFFDF,
        20'hFFFE3, 20'hFFFEB, 20'hFFFEF, 20'hFFFF3, 20'hFFFF7, 20'hFFFFB};
    localparam logic [CMD_AW-1:0] ROM_CODE_PROTECT_ADDR = 20'h0FFFF;
    localparam logic [7:0] ROM_CODE_PROTECT_OPEN = 8'hFF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // Auto operation time and clock
    localparam int CLK_PERIOD_NS = 50;
    localparam int AUTO_TIME_NS = 10000;
    localparam int AUTO_CYC = (AUTO_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int CNT_W = 16;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PROG_ARM,
        ST_LOCK_ARM,
        ST_BUSY
    } fcrs_state_t;
endpackage

//--- design/fcrs_guard.sv
// One rewrite control bit that sets only by a zero-then-one write pair
module fcrs_guard (
    input wire logic clk_in,    // System clock
    input wire logic sys_rst_in, // Async reset, active high
    input wire logic wr_in,     // Write to this bit's register
    input wire logic val_in,    // Written value of this bit
    input wire logic brk_in,    // Any other access breaks the pair
    input wire logic nmi_n_in,  // Interrupt pin level, low active
    input wire logic clr_in,    // Forced reset on abort
    output logic bit_out        // Current bit value
);
    import fcrs_pkg::*;

    logic armed;

    // (R9) zero then one
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            armed <= 1'b0;
            bit_out <= 1'b0;
        end else if (clr_in) begin
            armed <= 1'b0;
            bit_out <= 1'b0;
        end else if (wr_in) begin
            if (!val_in) begin
                bit_out <= 1'b0;
                armed <= 1'b1;
            end else begin
                // Pin must be high at the one write itself
                if (armed && nmi_n_in) begin
                    bit_out <= 1'b1;
                end
                armed <= 1'b0;
            end
        end else if (brk_in) begin
            armed <= 1'b0;
        end
    end
endmodule // fcrs_guard

//--- design/fcrs_protect.sv
// Identification and code protect checks for programmer access
module fcrs_protect (
    input wire logic clk_in,     // System clock
    input wire logic sys_rst_in, // Async reset, active high
    input wire logic wr_in,      // Program write into the array
    input wire logic [fcrs_pkg::CMD_AW-1:0] addr_in, // Program address
    input wire logic [7:0] data_in, // Programmed upper byte
    input wire logic [8*fcrs_pkg::ID_NUM-1:0] check_in, // Check values
    output logic ser_ok_out,     // Serial programmer access allowed
    output logic par_ok_out      // Parallel programmer access allowed
);
    import fcrs_pkg::*;

    logic [7:0] id_mem [ID_NUM];
    logic [7:0] rom_cp;
    logic [ID_NUM-1:0] id_match;

    // (R1) id byte capture
    // Check bytes sit at odd addresses: the upper byte of an even word
    generate
        for (genvar i = 0; i < ID_NUM; i++) begin : g_id
            always_ff @(posedge clk_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    id_mem[i] <= ERASED_BYTE;
                end else if (wr_in && addr_in[CMD_AW-1:1]
                    == ID_ADDR[i][CMD_AW-1:1]) begin
                    id_mem[i] <= data_in;
                end
            end
            assign id_match[i] = id_mem[i] == check_in[8*i +: 8];
        end
    endgenerate

    // (R2) protect byte capture
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rom_cp <= ERASED_BYTE;
        end else if (wr_in && addr_in[CMD_AW-1:1]
            == ROM_CODE_PROTECT_ADDR[CMD_AW-1:1]) begin
            rom_cp <= data_in;
        end
    end

    // (R1) serial access gate
    assign ser_ok_out = &id_match;
    // (R2) parallel access gate
    assign par_ok_out = rom_cp == ROM_CODE_PROTECT_OPEN;

    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    a_id_refuse: assert property ( // R1
        wr_in && addr_in[CMD_AW-1:1] == ID_ADDR[0][CMD_AW-1:1]
        && data_in != check_in[7:0] |=> !ser_ok_out)
    else $error("serial access allowed with wrong id byte");

    a_rom_code_protect_refuse: assert property ( // R2
        wr_in && addr_in[CMD_AW-1:1] == ROM_CODE_PROTECT_ADDR[CMD_AW-1:1]
        && data_in != ROM_CODE_PROTECT_OPEN
        |=> !par_ok_out [*2])
    else $error("parallel access allowed while protected");
endmodule // fcrs_protect

//--- design/fcrs_sequencer.sv
// Flash rewrite command sequencer with control registers and protection
// Behaviour
// (R1) Serial access refused on id byte mismatch
// (R2) Parallel access refused when protect byte set
// (R3) Commands and data go to even addresses
// (R4) Code 40h then data starts auto program
// (R5) Program uses same address both cycles
// (R6) 77h then D0h clears block lock bit
// (R7) Lock command uses same address both cycles
// (R8) No commands while main clock stopped
// (R9) Guarded bits set by zero-one pair, pin high
// (R10) No interrupt or transfer inside pair
// (R11) Interrupt events reset control, abort rewrite
// (R12) No transfer while busy in resident mode
// (R13) Clear rewrite enable before stop mode
// (R14) Clear rewrite enable before wait
// (R15) Set clock and wait state before rewrite
// (R16) Resident mode avoids watchdog and vector interrupts
// (R17) Re-enable rewrite after interrupt to repower
// (R18) Busy flag low throughout auto operation
//
// Decided for this implementation: the address-and-strobe port and the address map.
module fcrs_sequencer #(
    parameter int AUTO_CYCLES = fcrs_pkg::AUTO_CYC // Auto op length
) (
    input wire logic clk_in,      // System clock, 20 MHz
    input wire logic sys_rst_in,  // Async reset, active high
    input wire logic [fcrs_pkg::REG_AW-1:0] reg_addr_in, // Reg address
    input wire logic [fcrs_pkg::REG_DW-1:0] reg_wdata_in, // Write data
    input wire logic reg_we_in,   // Register write strobe
    input wire logic reg_re_in,   // Register read strobe
    output logic [fcrs_pkg::REG_DW-1:0] reg_rdata_out, // Read data
    input wire logic cmd_we_in,   // CPU write into flash space
    input wire logic [fcrs_pkg::CMD_AW-1:0] cmd_addr_in, // Flash address
    input wire logic [fcrs_pkg::CMD_DW-1:0] cmd_data_in, // Flash data
    input wire logic nmi_n_in,    // Non-maskable interrupt pin, low active
    input wire logic wdt_irq_in,  // Watchdog interrupt pulse
    input wire logic [8*fcrs_pkg::ID_NUM-1:0] id_check_in, // Id checks
    output logic ser_ok_out,      // Serial programmer access allowed
    output logic par_ok_out,      // Parallel programmer access allowed
    output logic pgm_start_out,   // Auto program start pulse
    output logic [fcrs_pkg::CMD_AW-1:0] pgm_addr_out, // Program address
    output logic [fcrs_pkg::CMD_DW-1:0] pgm_data_out, // Program data
    output logic lock_clr_out,    // Lock bit clear pulse
    output logic [fcrs_pkg::CMD_AW-1:0] lock_addr_out, // Block top addr
    output logic ready_busy_out,  // High when ready, low while busy
    output logic irq_out          // Level interrupt
);
    import fcrs_pkg::*;

    fcrs_state_t state;
    logic [CNT_W-1:0] busy_cnt;
    logic [CMD_AW-1:0] arm_addr;
    logic [GRD_NUM-1:0] guard_q;
    logic [GRD_NUM-1:0] grd_wr;
    logic cre;
    logic rc2;
    logic frm;
    logic cre_q;
    logic fps;
    logic nmi_q;
    logic abort;
    logic cmd_ok;
    logic op_start;
    logic lock_hit;
    logic op_done;
    logic cmd_err;
    logic [EV_NUM-1:0] ev;
    logic [EV_NUM-1:0] stat;
    logic [EV_NUM-1:0] mask;
    logic [EV_NUM-1:0] next_stat;
    logic [REG_DW-1:0] next_rdata;

    assign cre = guard_q[0];
    assign rc2 = guard_q[1];
    assign frm = guard_q[2];

    // Falling edge of the pin is the interrupt event
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            nmi_q <= 1'b1;
        end else begin
            nmi_q <= nmi_n_in;
        end
    end

    // (R11) abort source
    assign abort = (nmi_q && !nmi_n_in) || wdt_irq_in;

    // (R9) guarded control bits
    generate
        for (genvar g = 0; g < GRD_NUM; g++) begin : g_grd
            assign grd_wr[g] = reg_we_in && reg_addr_in == GRD_OFS[g];
            fcrs_guard u_guard (
                .clk_in(clk_in),
                .sys_rst_in(sys_rst_in),
                .wr_in(grd_wr[g]),
                .val_in(reg_wdata_in[GRD_BIT[g]]),
                .brk_in((reg_we_in || reg_re_in || cmd_we_in)
                    && !grd_wr[g]),
                .nmi_n_in(nmi_n_in),
                .clr_in(abort),
                .bit_out(guard_q[g])
            );
        end
    endgenerate

    // Power stop follows a fresh enable, so it must be re-enabled after abort
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cre_q <= 1'b0;
            fps <= 1'b0;
        end else begin
            cre_q <= cre;
            if (abort || !cre) begin
                fps <= 1'b0;
            end else if (!cre_q) begin
                fps <= 1'b1;
            end
        end
    end

    // (R3) odd addresses are ignored
    assign cmd_ok = cmd_we_in && !cmd_addr_in[0] && cre && !abort;
    // (R4) second cycle at same address
    assign op_start = state == ST_PROG_ARM && cmd_ok
        && cmd_addr_in == arm_addr;
    // (R6) confirm code at same address
    assign lock_hit = state == ST_LOCK_ARM && cmd_ok
        && cmd_addr_in == arm_addr
        && cmd_data_in[7:0] == CMD_LOCK_CONF;
    assign op_done = state == ST_BUSY && busy_cnt == '0 && !abort;
    assign cmd_err = cmd_ok && !op_start && !lock_hit
        && (state == ST_PROG_ARM || state == ST_LOCK_ARM
        || (state == ST_IDLE && cmd_data_in[7:0] != CMD_PROG
        && cmd_data_in[7:0] != CMD_LOCK));

    // Command sequence
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state <= ST_IDLE;
            arm_addr <= '0;
        end else if (abort) begin
            // (R11) abort to idle
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (cmd_ok && cmd_data_in[7:0] == CMD_PROG) begin
                        state <= ST_PROG_ARM;
                        arm_addr <= cmd_addr_in;
                    end else if (cmd_ok && cmd_data_in[7:0] == CMD_LOCK) begin
                        state <= ST_LOCK_ARM;
                        arm_addr <= cmd_addr_in;
                    end
                end
                ST_PROG_ARM: begin
                    if (op_start) begin
                        state <= ST_BUSY;
                    end else if (cmd_ok) begin
                        state <= ST_IDLE;
                    end
                end
                ST_LOCK_ARM: begin
                    if (lock_hit) begin
                        state <= ST_BUSY;
                    end else if (cmd_ok) begin
                        state <= ST_IDLE;
                    end
                end
                ST_BUSY: begin
                    // Writes during the auto operation are dropped
                    if (op_done) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // (R18) auto operation timer
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            busy_cnt <= '0;
        end else if (abort) begin
            busy_cnt <= '0;
        end else if (op_start || lock_hit) begin
            busy_cnt <= CNT_W'(AUTO_CYCLES - 1);
        end else if (state == ST_BUSY && busy_cnt != '0) begin
            busy_cnt <= busy_cnt - 1'b1;
        end
    end

    // (R18) busy flag
    assign ready_busy_out = state != ST_BUSY;

    // (R4) program launch
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pgm_start_out <= 1'b0;
            pgm_addr_out <= '0;
            pgm_data_out <= '0;
        end else begin
            pgm_start_out <= op_start;
            if (op_start) begin
                pgm_addr_out <= cmd_addr_in;
                pgm_data_out <= cmd_data_in;
            end
        end
    end

    // (R6) lock bit clear
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            lock_clr_out <= 1'b0;
            lock_addr_out <= '0;
        end else begin
            lock_clr_out <= lock_hit;
            if (lock_hit) begin
                lock_addr_out <= cmd_addr_in;
            end
        end
    end

    // Programs reaching the check bytes update the protection state
    fcrs_protect u_protect (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .wr_in(pgm_start_out),
        .addr_in(pgm_addr_out),
        .data_in(pgm_data_out[CMD_DW-1 -: 8]),
        .check_in(id_check_in),
        .ser_ok_out(ser_ok_out),
        .par_ok_out(par_ok_out)
    );

    // Sticky events; a new event beats a clear in the same cycle
    always_comb begin
        ev = '0;
        ev[EV_DONE] = op_done;
        ev[EV_ABORT] = abort;
        ev[EV_ERR] = cmd_err;
        next_stat = stat;
        if (reg_we_in && reg_addr_in == OFS_STAT) begin
            next_stat = stat & ~reg_wdata_in[EV_NUM-1:0];
        end
        next_stat = next_stat | ev;
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            stat <= EV_RST;
            mask <= EV_RST;
        end else begin
            stat <= next_stat;
            if (reg_we_in && reg_addr_in == OFS_MASK) begin
                mask <= reg_wdata_in[EV_NUM-1:0];
            end
        end
    end

    assign irq_out = |(stat & mask);

    // Read mux; unmapped addresses read zero
    always_comb begin
        next_rdata = '0;
        unique case (reg_addr_in)
            OFS_CTRL_A: begin
                next_rdata[BIT_RBF] = ready_busy_out;
                next_rdata[BIT_CRE] = cre;
                next_rdata[BIT_RC2] = rc2;
                next_rdata[BIT_FPS] = fps;
                next_rdata[BIT_SER_OK] = ser_ok_out;
                next_rdata[BIT_PAR_OK] = par_ok_out;
            end
            OFS_CTRL_B: next_rdata[BIT_FRM] = frm;
            OFS_STAT: next_rdata[EV_NUM-1:0] = stat;
            OFS_MASK: next_rdata[EV_NUM-1:0] = mask;
            default: next_rdata = '0;
        endcase
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= '0;
        end else if (reg_re_in) begin
            reg_rdata_out <= next_rdata;
        end else begin
            reg_rdata_out <= '0;
        end
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_cre_zero;
        reg_we_in && reg_addr_in == OFS_CTRL_A
            && !reg_wdata_in[BIT_CRE] && !abort;
    endsequence

    sequence s_cre_one;
        reg_we_in && reg_addr_in == OFS_CTRL_A
            && reg_wdata_in[BIT_CRE] && nmi_n_in && !abort;
    endsequence

    a_guard_set_pair: assert property ( // R9
        s_cre_zero ##1 s_cre_one |=> cre)
    else $error("zero-one pair did not set rewrite enable");

    a_guard_set_cause: assert property ( // R9
        $rose(cre) |-> $past(nmi_n_in) && $past(reg_we_in)
            && $past(reg_addr_in) == OFS_CTRL_A)
    else $error("rewrite enable set without a guarded write");

    a_abort_reset: assert property ( // R11
        abort |=> state == ST_IDLE && !cre && !rc2 && !frm && !fps)
    else $error("interrupt event did not reset control");

    a_prog_launch: assert property ( // R4
        op_start && !abort |=> pgm_start_out && !ready_busy_out
            && pgm_addr_out == $past(cmd_addr_in))
    else $error("program command did not start auto operation");

    a_lock_clear: assert property ( // R6
        lock_hit |=> lock_clr_out && lock_addr_out == $past(cmd_addr_in))
    else $error("lock command did not clear the lock bit");

    a_busy_load: assert property ( // R18
        $fell(ready_busy_out) |-> busy_cnt == CNT_W'(AUTO_CYCLES - 1))
    else $error("busy began without a full operation time");

    a_busy_end: assert property ( // R18
        $rose(ready_busy_out) |-> $past(abort) || $past(busy_cnt) == '0)
    else $error("ready returned before the operation finished");

    a_odd_ignored: assert property ( // R3
        state == ST_IDLE && cmd_we_in && cmd_addr_in[0] |=> state == ST_IDLE)
    else $error("odd address command was accepted");
endmodule // fcrs_sequencer

//--- sim/fcrs_cpu_model.sv
// CPU-side model that issues flash command writes
module fcrs_cpu_model (
    input wire logic clk_in, // System clock
    output logic cmd_we_out, // Flash space write strobe
    output logic [fcrs_pkg::CMD_AW-1:0] cmd_addr_out, // Flash address
    output logic [fcrs_pkg::CMD_DW-1:0] cmd_data_out // Flash data
);
    timeunit 1ns;
    timeprecision 1ns;
    import fcrs_pkg::*;
    bit main_clock_stop = 1'b0;
    // Set by the bench only where an odd address is meant to be refused
    bit fault_ok = 1'b0;
    // no transfer or vector interrupt is modelled during busy
    // stop and wait are never entered, so enable stays as set
    // clock and wait state are taken as set before the enable pair
    initial begin
        cmd_we_out = 1'b0;
        cmd_addr_out = 20'h00000;
        cmd_data_out = 16'h0000;
    end
    // one bus cycle of a command, held to its sampling edge
    task automatic wr(input logic [CMD_AW-1:0] a, input logic [CMD_DW-1:0] d);
        // nothing is issued while the main clock is stopped
        if (main_clock_stop)
            return;
        if (a[0] && !fault_ok)
            return;
        @(posedge clk_in);
        cmd_we_out <= 1'b1;
        cmd_addr_out <= a;
        cmd_data_out <= d;
        @(posedge clk_in);
        cmd_we_out <= 1'b0;
        // Released lines change so a stale value is never mistaken for data
        cmd_addr_out <= ~a;
        cmd_data_out <= ~d;
    endtask
endmodule // fcrs_cpu_model

//--- sim/tb.sv
// Self-checking bench for the flash rewrite sequencer
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import fcrs_pkg::*;
    localparam int AC = 8;
    typedef struct {
        logic [CMD_AW-1:0] a1;
        logic [CMD_DW-1:0] d1;
        logic [CMD_AW-1:0] a2;
        logic [CMD_DW-1:0] d2;
        logic st;
        logic lk;
        logic [2:0] ev;
    } fcrs_row_t;
    // First write, second write, start, lock clear, status
    fcrs_row_t rows [6] = '{
        '{20'h01000, 16'hFF40, 20'h01000, 16'hA5C3, 1'b1, 1'b0, 3'h1},
        '{20'h0BFFE, 16'h0077, 20'h0BFFE, 16'h12D0, 1'b0, 1'b1, 3'h1},
        '{20'h01000, 16'h0077, 20'h01000, 16'h0040, 1'b0, 1'b0, 3'h4},
        '{20'h01000, 16'h0040, 20'h01002, 16'h1234, 1'b0, 1'b0, 3'h4},
        '{20'h01000, 16'h0012, 20'h01000, 16'h0034, 1'b0, 1'b0, 3'h4},
        '{20'h01001, 16'h0040, 20'h01001, 16'h5555, 1'b0, 1'b0, 3'h0}};
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [REG_AW-1:0] reg_addr_in = 4'h0;
    logic [REG_DW-1:0] reg_wdata_in = 32'h0;
    logic reg_we_in = 1'b0;
    logic reg_re_in = 1'b0;
    logic [REG_DW-1:0] reg_rdata_out;
    logic cmd_we_in;
    logic [CMD_AW-1:0] cmd_addr_in, pgm_addr_out, lock_addr_out;
    logic [CMD_DW-1:0] cmd_data_in, pgm_data_out;
    logic nmi_n_in = 1'b1;
    logic wdt_irq_in = 1'b0;
    logic [8*ID_NUM-1:0] id_check_in = {ID_NUM{8'hFF}};
    logic ser_ok_out, par_ok_out, pgm_start_out, lock_clr_out;
    logic ready_busy_out, irq_out;
    int errors = 0;
    int n_checks = 0;

    always #25 clk_in = ~clk_in;

    fcrs_sequencer #(.AUTO_CYCLES(AC)) dut (.clk_in(clk_in),
        .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_we_in(reg_we_in),
        .reg_re_in(reg_re_in), .reg_rdata_out(reg_rdata_out),
        .cmd_we_in(cmd_we_in), .cmd_addr_in(cmd_addr_in),
        .cmd_data_in(cmd_data_in), .nmi_n_in(nmi_n_in),
        .wdt_irq_in(wdt_irq_in), .id_check_in(id_check_in),
        .ser_ok_out(ser_ok_out), .par_ok_out(par_ok_out),
        .pgm_start_out(pgm_start_out), .pgm_addr_out(pgm_addr_out),
        .pgm_data_out(pgm_data_out), .lock_clr_out(lock_clr_out),
        .lock_addr_out(lock_addr_out), .ready_busy_out(ready_busy_out),
        .irq_out(irq_out));

    fcrs_cpu_model cpu (.clk_in(clk_in), .cmd_we_out(cmd_we_in),
        .cmd_addr_out(cmd_addr_in), .cmd_data_out(cmd_data_in));

    task automatic chk(input string nm, input logic [31:0] s,
        input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wr_reg(input logic [REG_AW-1:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_we_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_we_in <= 1'b0;
    endtask

    task automatic rd_chk(input logic [REG_AW-1:0] a, input logic [31:0] e);
        @(posedge clk_in);
        reg_re_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_re_in <= 1'b0;
        #1;
        chk("rdata", reg_rdata_out, e);
    endtask

    // Zero then value on back-to-back cycles, nothing in between
    task automatic guard(input logic [REG_AW-1:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_we_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= 32'h0;
        @(posedge clk_in);
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_we_in <= 1'b0;
    endtask

    task automatic stop_test();
        $display("Checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Whole run is under two hundred cycles; this bound only cuts a hang
    initial begin
        repeat (4000) @(posedge clk_in);
        errors++;
        stop_test();
    end

    initial begin
        repeat (6) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        #1;
        chk("ready_busy", 32'(ready_busy_out), 32'h1);
        chk("irq", 32'(irq_out), 32'h0);
        rd_chk(OFS_CTRL_A, 32'h31);
        rd_chk(OFS_CTRL_B, 32'h0);
        rd_chk(OFS_STAT, 32'h0);
        rd_chk(OFS_MASK, 32'h0);
        rd_chk(4'h2, 32'h0);
        wr_reg(OFS_CTRL_A, 32'h0);
        rd_chk(OFS_CTRL_A, 32'h31);
        wr_reg(OFS_CTRL_A, 32'h6);
        rd_chk(OFS_CTRL_A, 32'h31);
        guard(OFS_CTRL_B, 32'h2);
        rd_chk(OFS_CTRL_B, 32'h2);
        guard(OFS_CTRL_A, 32'h6);
        rd_chk(OFS_CTRL_A, 32'h3F);
        foreach (rows[i]) begin
            cpu.fault_ok = rows[i].a1[0];
            // matched addresses in both cycles except the address-mismatch row
            cpu.wr(rows[i].a1, rows[i].d1);
            cpu.wr(rows[i].a2, rows[i].d2);
            #1;
            chk("pgm_start", 32'(pgm_start_out), 32'(rows[i].st));
            chk("lock_clr", 32'(lock_clr_out), 32'(rows[i].lk));
            chk("ready_busy", 32'(ready_busy_out),
                32'(!(rows[i].st || rows[i].lk)));
            if (rows[i].st) begin
                chk("pgm_addr", 32'(pgm_addr_out), 32'(rows[i].a2));
                chk("pgm_data", 32'(pgm_data_out), 32'(rows[i].d2));
            end
            if (rows[i].lk)
                chk("lock_addr", 32'(lock_addr_out), 32'(rows[i].a2));
            if (rows[i].st | rows[i].lk) begin
                repeat (AC - 1) @(posedge clk_in);
                #1;
                chk("ready_busy", 32'(ready_busy_out), 32'h0);
                @(posedge clk_in);
                #1;
                chk("ready_busy", 32'(ready_busy_out), 32'h1);
            end
            rd_chk(OFS_STAT, 32'(rows[i].ev));
            wr_reg(OFS_STAT, 32'h7);
        end
        cpu.fault_ok = 1'b0;
        wr_reg(OFS_MASK, 32'h2);
        cpu.wr(20'h02000, 16'h0012);
        #1;
        chk("irq", 32'(irq_out), 32'h0);
        wr_reg(OFS_STAT, 32'h4);
        // leave resident mode before the watchdog is used
        wr_reg(OFS_CTRL_B, 32'h0);
        cpu.wr(20'h02000, 16'h0040);
        cpu.wr(20'h02000, 16'hBEEF);
        cpu.wr(20'h02000, 16'h0040);
        @(posedge clk_in);
        wdt_irq_in <= 1'b1;
        @(posedge clk_in);
        wdt_irq_in <= 1'b0;
        #1;
        chk("ready_busy", 32'(ready_busy_out), 32'h1);
        chk("irq", 32'(irq_out), 32'h1);
        rd_chk(OFS_STAT, 32'h2);
        rd_chk(OFS_CTRL_A, 32'h31);
        wr_reg(OFS_STAT, 32'h2);
        #1;
        chk("irq", 32'(irq_out), 32'h0);
        // rewrite enabled again once the interrupt is served
        guard(OFS_CTRL_A, 32'h2);
        rd_chk(OFS_CTRL_A, 32'h3B);
        @(posedge clk_in);
        nmi_n_in <= 1'b0;
        rd_chk(OFS_CTRL_A, 32'h31);
        rd_chk(OFS_STAT, 32'h2);
        guard(OFS_CTRL_A, 32'h2);
        rd_chk(OFS_CTRL_A, 32'h31);
        @(posedge clk_in);
        nmi_n_in <= 1'b1;
        id_check_in <= {8'h00, {(ID_NUM - 1){8'hFF}}};
        #1;
        chk("ser_ok", 32'(ser_ok_out), 32'h0);
        chk("par_ok", 32'(par_ok_out), 32'h1);
        @(posedge clk_in);
        id_check_in <= {ID_NUM{8'hFF}};
        #1;
        chk("ser_ok", 32'(ser_ok_out), 32'h1);
        // Check bytes are the upper byte of an even word program
        guard(OFS_CTRL_A, 32'h2);
        cpu.wr(20'hFFFDE, 16'h0040);
        cpu.wr(20'hFFFDE, 16'h12AB);
        @(posedge clk_in);
        #1;
        chk("ser_ok", 32'(ser_ok_out), 32'h0);
        repeat (AC) @(posedge clk_in);
        cpu.wr(20'h0FFFE, 16'h0040);
        cpu.wr(20'h0FFFE, 16'h00CD);
        @(posedge clk_in);
        #1;
        chk("par_ok", 32'(par_ok_out), 32'h0);
        @(posedge clk_in);
        id_check_in <= {{(ID_NUM - 1){8'hFF}}, 8'h12};
        #1;
        chk("ser_ok", 32'(ser_ok_out), 32'h1);
        stop_test();
    end
endmodule // tb
